/* ccpc_pkg.sv */
// package: register map, field positions and timing constants for the codec clock control block
package ccpc_pkg;

  // register addresses on the control port
  localparam logic [7:0] CCPC_ADDR_CLOCK_SETUP = 8'h00;
  localparam logic [7:0] CCPC_ADDR_DEN_HIGH    = 8'h01;
  localparam logic [7:0] CCPC_ADDR_DEN_LOW     = 8'h02;
  localparam logic [7:0] CCPC_ADDR_NUM_HIGH    = 8'h03;
  localparam logic [7:0] CCPC_ADDR_NUM_LOW     = 8'h04;
  localparam logic [7:0] CCPC_ADDR_MODE_INT    = 8'h05;
  localparam logic [7:0] CCPC_ADDR_LOCK_STATE  = 8'h06;
  localparam logic [7:0] CCPC_ADDR_DSP_RUN     = 8'h09;
  localparam logic [7:0] CCPC_ADDR_OUT_CTRL    = 8'h0a;

  // clock_setup fields
  localparam int CCPC_BIT_CORE_EN   = 0;
  localparam int CCPC_BIT_SRC_SEL   = 3;
  localparam int CCPC_BIT_CDIV      = 1;
  localparam int CCPC_BIT_MDIV      = 2;
  localparam int CCPC_BIT_PLL_EN    = 7;
  // mode/integer register fields
  localparam int CCPC_BIT_FRAC      = 0;
  localparam int CCPC_PREDIV_LSB    = 1;
  localparam int CCPC_PREDIV_MSB    = 2;
  localparam int CCPC_INT_LSB       = 3;
  localparam int CCPC_INT_MSB       = 6;
  // lock register and run register
  localparam int CCPC_BIT_LOCK      = 0;
  localparam int CCPC_BIT_RUN       = 0;
  localparam int CCPC_SINC_A_BIT    = 1;
  localparam int CCPC_SINC_B_BIT    = 2;
  localparam int CCPC_DACSEL_A_BIT  = 3;
  localparam int CCPC_DACSEL_B_BIT  = 4;
  // clock output control fields
  localparam int CCPC_OUT_FAC_LSB   = 0;
  localparam int CCPC_OUT_FAC_MSB   = 2;
  localparam int CCPC_BIT_PDM       = 3;
  localparam int CCPC_BIT_SUPPLY_GOOD_SIGNAL_EN  = 4;

  // clock output factor codes
  localparam logic [2:0] CCPC_FAC_X2    = 3'h0;
  localparam logic [2:0] CCPC_FAC_X1    = 3'h1;
  localparam logic [2:0] CCPC_FAC_HALF  = 3'h2;
  localparam logic [2:0] CCPC_FAC_QUART = 3'h3;
  localparam logic [2:0] CCPC_FAC_EIGHT = 3'h4;

  localparam logic [7:0] CCPC_ZERO_BYTE = 8'h00;

  // timing
  localparam int CCPC_CLK_HZ          = 20000000;
  localparam int CCPC_POR_TIME_MS     = 15;
  localparam int CCPC_POR_CYCLES      = (CCPC_CLK_HZ / 1000) * CCPC_POR_TIME_MS;
  localparam int CCPC_LOCK_CYCLES_DEF = 1024;   // modelled acquisition time, plain default

  // pll lock acquisition states (gray along the path)
  typedef enum logic [1:0] {
    CCPC_PLL_OFF  = 2'b00,
    CCPC_PLL_ACQ  = 2'b01,
    CCPC_PLL_LOCK = 2'b11
  } ccpc_pll_state_t;

  // control port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccpc_req_t;

  // synthesiser settings seen by the analogue pll
  typedef struct packed {
    logic        enable;
    logic        fractional;
    logic [1:0]  prediv;
    logic [3:0]  integer_r;
    logic [15:0] numerator;
    logic [15:0] denominator;
  } ccpc_synth_t;

  // block state except the input synchronisers
  typedef struct packed {
    logic [7:0]      clock_setup;
    logic [7:0]      den_high;
    logic [7:0]      den_low;
    logic [7:0]      num_high;
    logic [7:0]      num_low;
    logic [7:0]      mode_int;
    logic [7:0]      dsp_run;
    logic [7:0]      out_ctrl;
    ccpc_pll_state_t pll_state;
    logic [23:0]     count;
    logic            in_reset;
    logic [7:0]      rdata;
    logic            rvalid;
    logic            refused;
    logic [3:0]      div_cnt;
    logic            clk_out;
    logic            supply_good_signal_prev;
    logic            dac_mute;
  } ccpc_state_t;

endpackage : ccpc_pkg

/* ccpc_clock_control.sv */
// codec clock generation, pll control, start-up gating and power mute logic
`timescale 1ns/10ps
//
// Overview of operation
// - core clocks gated until core enable set
// - divider bits both one divide by one
// - dividers fixed after setup; source switchable live
// - internal reset held 15 ms after power
// - core enable refused until lock reported, while pll enabled
// - only registers 0 to 6 before lock
// - predivider ratio from mode bits two:one
// - integer mode ignores numerator and denominator
// - clock output scaled master, pdm limits
// - power-down pin shuts everything down
// - supply good change mutes both dacs
module ccpc_clock_control
  import ccpc_pkg::*;
#(
  parameter int POR_CYCLES  = CCPC_POR_CYCLES,
  parameter int LOCK_CYCLES = CCPC_LOCK_CYCLES_DEF
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        power_down_pin_n,   // active low pin, asynchronous source
  input  wire logic        supply_good_signal, // multipurpose pin, asynchronous source
  input  wire ccpc_req_t   req,                // control port request, same clock
  output logic [7:0]       rdata,              // read data, registered
  output logic             rvalid,             // read answer pulse
  output logic             refused,            // access refused pulse
  output ccpc_synth_t      synth,              // settings to the pll
  output logic             clock_source_select,
  output logic             master_clock_divider_sel,
  output logic             core_clock_divider_sel,
  output logic             core_clock_gate,    // master and core clock running
  output logic             internal_reset,     // held after power-up
  output logic             dac_mute,           // both dacs muted
  output logic             clock_output_pin,   // scaled master clock
  output logic             decim_sinc_sel_a,
  output logic             decim_sinc_sel_b,
  output logic             dac_input_sel_a,
  output logic             dac_input_sel_b
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0] pd_sync_reg;  // first stage read only by second
  logic [1:0] pg_sync_reg;
  logic       pd_active;    // power down requested
  logic       supply_good_signal_s;

  // two flops per pin before any logic sees it
  always_ff @(posedge clk) begin
    if (srst) begin
      // power-down pin idles high: a low reset value would fake a power-down
      // and leave the sticky dac mute set straight after every reset
      pd_sync_reg <= 2'b11;
      pg_sync_reg <= 2'b00;
    end else begin
      pd_sync_reg <= {pd_sync_reg[0], power_down_pin_n};
      pg_sync_reg <= {pg_sync_reg[0], supply_good_signal};
    end
  end
  assign pd_active = ~pd_sync_reg[1];
  assign supply_good_signal_s   = pg_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // state
  ccpc_state_t state_reg;
  ccpc_state_t state_next;
  logic        locked;       // pll reached lock
  logic        open_access;  // whole map reachable
  logic        in_low_map;   // address within 0..6
  logic [3:0]  half_period;  // clock output half period in fast clocks
  logic        out_allowed;  // factor usable in current mode

  assign locked      = (state_reg.pll_state == CCPC_PLL_LOCK);
  assign open_access = state_reg.clock_setup[CCPC_BIT_CORE_EN] & locked;
  assign in_low_map  = (req.addr <= CCPC_ADDR_LOCK_STATE);

  // master-clock scaling, modelled as a divider of the fast clock
  always_comb begin
    half_period = 4'h1;
    out_allowed = 1'b1;
    case (state_reg.out_ctrl[CCPC_OUT_FAC_MSB:CCPC_OUT_FAC_LSB])
      CCPC_FAC_X2: begin
        half_period = 4'h1;
        // doubling only valid after the input divide by two
        out_allowed = ~state_reg.clock_setup[CCPC_BIT_MDIV] &
                      ~state_reg.out_ctrl[CCPC_BIT_PDM];
      end
      CCPC_FAC_X1: begin
        half_period = 4'h2;
        out_allowed = ~state_reg.out_ctrl[CCPC_BIT_PDM];
      end
      CCPC_FAC_HALF:  half_period = 4'h3;
      CCPC_FAC_QUART: half_period = 4'h5;
      CCPC_FAC_EIGHT: half_period = 4'h9;
      default:        out_allowed = 1'b0;
    endcase
  end

  // next-state logic: registers, lock tracking, reset timer, mute
  always_comb begin
    state_next         = state_reg;
    state_next.rvalid  = 1'b0;
    state_next.refused = 1'b0;

    // internal reset timer after power-up
    if (state_reg.in_reset) begin
      if (state_reg.count >= 24'(POR_CYCLES - 1)) begin
        state_next.in_reset = 1'b0;
        state_next.count    = 24'h000000;
      end else begin
        state_next.count = state_reg.count + 24'h000001;
      end
    end else begin
      // pll lock model
      case (state_reg.pll_state)
        CCPC_PLL_OFF: begin
          state_next.count = 24'h000000;
          if (state_reg.clock_setup[CCPC_BIT_PLL_EN]) begin
            state_next.pll_state = CCPC_PLL_ACQ;
          end
        end
        CCPC_PLL_ACQ: begin
          if (!state_reg.clock_setup[CCPC_BIT_PLL_EN]) begin
            state_next.pll_state = CCPC_PLL_OFF;
          end else if (state_reg.count >= 24'(LOCK_CYCLES - 1)) begin
            state_next.pll_state = CCPC_PLL_LOCK;
          end else begin
            state_next.count = state_reg.count + 24'h000001;
          end
        end
        CCPC_PLL_LOCK: begin
          if (!state_reg.clock_setup[CCPC_BIT_PLL_EN]) begin
            state_next.pll_state = CCPC_PLL_OFF;
          end
        end
        default: state_next.pll_state = CCPC_PLL_OFF;
      endcase

      // control port writes
      if (req.wr) begin
        if (!in_low_map && !open_access) begin
          state_next.refused = 1'b1;
        end else if (req.addr == CCPC_ADDR_CLOCK_SETUP) begin
          state_next.clock_setup = req.wdata;
          // dividers frozen once the core runs; source may still change
          if (state_reg.clock_setup[CCPC_BIT_CORE_EN]) begin
            state_next.clock_setup[CCPC_BIT_MDIV] = state_reg.clock_setup[CCPC_BIT_MDIV];
            state_next.clock_setup[CCPC_BIT_CDIV] = state_reg.clock_setup[CCPC_BIT_CDIV];
          end
          // core enable refused while pll used but unlocked
          if (req.wdata[CCPC_BIT_PLL_EN] && !locked) begin
            state_next.clock_setup[CCPC_BIT_CORE_EN] = 1'b0;
          end
        end else if (req.addr == CCPC_ADDR_DEN_HIGH) begin
          state_next.den_high = req.wdata;
        end else if (req.addr == CCPC_ADDR_DEN_LOW) begin
          state_next.den_low = req.wdata;
        end else if (req.addr == CCPC_ADDR_NUM_HIGH) begin
          state_next.num_high = req.wdata;
        end else if (req.addr == CCPC_ADDR_NUM_LOW) begin
          state_next.num_low = req.wdata;
        end else if (req.addr == CCPC_ADDR_MODE_INT) begin
          state_next.mode_int = req.wdata;
        end else if (req.addr == CCPC_ADDR_DSP_RUN) begin
          state_next.dsp_run = req.wdata;
        end else if (req.addr == CCPC_ADDR_OUT_CTRL) begin
          state_next.out_ctrl = req.wdata;
        end
      end

      // control port reads
      if (req.rd) begin
        state_next.rvalid = 1'b1;
        state_next.rdata  = CCPC_ZERO_BYTE;
        if (!in_low_map && !open_access) begin
          state_next.refused = 1'b1;
        end else if (req.addr == CCPC_ADDR_CLOCK_SETUP) begin
          state_next.rdata = state_reg.clock_setup;
        end else if (req.addr == CCPC_ADDR_DEN_HIGH) begin
          state_next.rdata = state_reg.den_high;
        end else if (req.addr == CCPC_ADDR_DEN_LOW) begin
          state_next.rdata = state_reg.den_low;
        end else if (req.addr == CCPC_ADDR_NUM_HIGH) begin
          state_next.rdata = state_reg.num_high;
        end else if (req.addr == CCPC_ADDR_NUM_LOW) begin
          state_next.rdata = state_reg.num_low;
        end else if (req.addr == CCPC_ADDR_MODE_INT) begin
          state_next.rdata = state_reg.mode_int;
        end else if (req.addr == CCPC_ADDR_LOCK_STATE) begin
          state_next.rdata[CCPC_BIT_LOCK] = locked;
        end else if (req.addr == CCPC_ADDR_DSP_RUN) begin
          state_next.rdata = state_reg.dsp_run;
        end else if (req.addr == CCPC_ADDR_OUT_CTRL) begin
          state_next.rdata = state_reg.out_ctrl;
        end
      end
    end

    // clock output divider, runs only with the core clock
    if (state_reg.clock_setup[CCPC_BIT_CORE_EN] && out_allowed && !state_reg.in_reset) begin
      if (state_reg.div_cnt >= half_period - 4'h1) begin
        state_next.div_cnt = 4'h0;
        state_next.clk_out = ~state_reg.clk_out;
      end else begin
        state_next.div_cnt = state_reg.div_cnt + 4'h1;
      end
    end else begin
      state_next.div_cnt = 4'h0;
      state_next.clk_out = 1'b0;
    end

    // supply-good change mutes both dacs when the pin is so configured
    state_next.supply_good_signal_prev = supply_good_signal_s;
    if (state_reg.out_ctrl[CCPC_BIT_SUPPLY_GOOD_SIGNAL_EN] && (supply_good_signal_s != state_reg.supply_good_signal_prev)) begin
      state_next.dac_mute = 1'b1;
    end

    // power-down pin returns everything to the reset state, except that it sets the dac mute and loads the current supply-good level
    if (pd_active) begin
      state_next            = '0;
      state_next.in_reset   = 1'b1;
      state_next.supply_good_signal_prev = supply_good_signal_s;
      state_next.dac_mute   = 1'b1;
    end
  end

  // state register; reset enters the power-up internal reset
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg          <= '0;
      state_reg.in_reset <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata   = state_reg.rdata;
  assign rvalid  = state_reg.rvalid;
  assign refused = state_reg.refused;

  assign synth.enable      = state_reg.clock_setup[CCPC_BIT_PLL_EN];
  assign synth.fractional  = state_reg.mode_int[CCPC_BIT_FRAC];
  assign synth.prediv      = state_reg.mode_int[CCPC_PREDIV_MSB:CCPC_PREDIV_LSB];
  assign synth.integer_r   = state_reg.mode_int[CCPC_INT_MSB:CCPC_INT_LSB];
  // integer mode forces the fraction terms to zero
  assign synth.numerator   = state_reg.mode_int[CCPC_BIT_FRAC] ?
                             {state_reg.num_high, state_reg.num_low} : 16'h0000;
  assign synth.denominator = state_reg.mode_int[CCPC_BIT_FRAC] ?
                             {state_reg.den_high, state_reg.den_low} : 16'h0000;

  assign clock_source_select      = state_reg.clock_setup[CCPC_BIT_SRC_SEL];
  assign master_clock_divider_sel = state_reg.clock_setup[CCPC_BIT_MDIV];
  assign core_clock_divider_sel   = state_reg.clock_setup[CCPC_BIT_CDIV];
  // gate held off until software enables the core
  assign core_clock_gate  = state_reg.clock_setup[CCPC_BIT_CORE_EN] & ~state_reg.in_reset;
  assign internal_reset   = state_reg.in_reset;
  assign dac_mute         = state_reg.dac_mute;
  assign clock_output_pin = state_reg.clk_out;
  assign decim_sinc_sel_a = state_reg.dsp_run[CCPC_SINC_A_BIT];
  assign decim_sinc_sel_b = state_reg.dsp_run[CCPC_SINC_B_BIT];
  assign dac_input_sel_a  = state_reg.dsp_run[CCPC_DACSEL_A_BIT];
  assign dac_input_sel_b  = state_reg.dsp_run[CCPC_DACSEL_B_BIT];

endmodule // ccpc_clock_control

/* ccpc_clock_control_assertions.sv */
// concurrent checks on the ports of the codec clock control block
`timescale 1ns/10ps
module ccpc_clock_control_checker
  import ccpc_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        power_down_pin_n,
  input wire ccpc_req_t   req,
  input wire logic        rvalid,
  input wire logic        refused,
  input wire ccpc_synth_t synth,
  input wire logic        master_clock_divider_sel,
  input wire logic        core_clock_divider_sel,
  input wire logic        core_clock_gate,
  input wire logic        internal_reset,
  input wire logic        dac_mute
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  // every taken read gets an answer one edge later
  AST_RD_ANSWER: assert property (req.rd && !internal_reset |=> rvalid || refused)
    else $error("read not answered");
  // requests during the start-up hold are ignored
  AST_POR_QUIET: assert property (internal_reset && req.rd |=> !rvalid)
    else $error("read answered during start-up hold");
  // no core clock while the start-up hold lasts
  AST_GATE_POR: assert property (internal_reset |-> !core_clock_gate)
    else $error("core clock running in start-up hold");
  // upper registers closed until the core runs with the pll locked
  AST_REFUSE_HIGH: assert property ((req.wr || req.rd) && !internal_reset && !core_clock_gate
    && req.addr > CCPC_ADDR_LOCK_STATE |=> refused)
    else $error("upper register reachable before core start");
  // integer mode hides the fraction from the synthesiser
  AST_INT_MODE: assert property (!synth.fractional |-> synth.numerator == 16'h0000
    && synth.denominator == 16'h0000)
    else $error("fraction seen in integer mode");
  // mode byte packing reaches the synthesiser one edge later
  AST_MODE_PACK: assert property (req.wr && !internal_reset && req.addr == CCPC_ADDR_MODE_INT
    |=> synth.prediv == $past(req.wdata[CCPC_PREDIV_MSB:CCPC_PREDIV_LSB])
    && synth.integer_r == $past(req.wdata[CCPC_INT_MSB:CCPC_INT_LSB])
    && synth.fractional == $past(req.wdata[CCPC_BIT_FRAC]))
    else $error("mode byte packing wrong");
  // dividers frozen while the core runs
  AST_DIV_HOLD: assert property (core_clock_gate && $past(core_clock_gate)
    |-> $stable(master_clock_divider_sel) && $stable(core_clock_divider_sel))
    else $error("divider changed while running");
  // power-down pin low shuts the block down after the synchroniser
  AST_PWR_DOWN: assert property (!power_down_pin_n [*4]
    |-> internal_reset && dac_mute && !core_clock_gate)
    else $error("power-down not obeyed");
  // mute holds until reset
  AST_MUTE_STICKY: assert property (dac_mute |=> dac_mute)
    else $error("dac mute released");
  // writes are ignored during the hold, so the core must still be off when it ends
  AST_GATE_AFTER_POR: assert property ($fell(internal_reset) |-> !core_clock_gate)
    else $error("core clock running when start-up hold ended");
  COV_REFUSE: cover property (refused);
  COV_CORE: cover property ($rose(core_clock_gate));
  COV_MUTE: cover property ($rose(dac_mute));
endmodule // ccpc_clock_control_checker

bind ccpc_clock_control ccpc_clock_control_checker i_ccpc_clock_control_checker (
  .clk(clk), .srst(srst), .power_down_pin_n(power_down_pin_n), .req(req),
  .rvalid(rvalid), .refused(refused), .synth(synth),
  .master_clock_divider_sel(master_clock_divider_sel),
  .core_clock_divider_sel(core_clock_divider_sel), .core_clock_gate(core_clock_gate),
  .internal_reset(internal_reset), .dac_mute(dac_mute));

/* ccpc_supply_model.sv */
// regulator model that drives the supply good line
`timescale 1ns/10ps
module ccpc_supply_model (
  input  wire logic clk,
  input  wire logic sag,               // rail starts to droop
  output logic      supply_good_signal // falls a little after the droop
);
  logic [1:0] dly_reg = 2'h0; // detector lag
  // the good line lags the rail, so the mute cannot count on an instant edge
  always_ff @(posedge clk) begin
    dly_reg <= {dly_reg[0], sag};
  end
  assign supply_good_signal = !dly_reg[1];
endmodule // ccpc_supply_model

/* test_ccpc_clock_control.sv */
// self-checking bench for the codec clock control block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_ccpc_clock_control;
  import ccpc_pkg::*;
  localparam int POR = 20;
  localparam int LCK = 8;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        power_down_pin_n = 1'b1;
  logic        sag = 1'b0;
  ccpc_req_t   req = '0;
  logic        supply_good_signal, rvalid, refused, clock_source_select;
  logic        master_clock_divider_sel, core_clock_divider_sel, core_clock_gate;
  logic        internal_reset, dac_mute, clock_output_pin;
  logic        decim_sinc_sel_a, decim_sinc_sel_b, dac_input_sel_a, dac_input_sel_b;
  logic [7:0]  rdata;
  ccpc_synth_t synth;
  int          mismatches = 0, samples_checked = 0, cyc = 0;
  int          m[16] = '{default: 0}; // model register file
  int          lck = 0;               // model lock state
  logic [31:0] rs = 32'h0000b62d;     // random state
  logic [7:0]  md[3] = '{8'h20, 8'h10, 8'h19};

  ccpc_clock_control #(.POR_CYCLES(POR), .LOCK_CYCLES(LCK)) i_ccpc_clock_control (
    .clk(clk), .srst(srst), .power_down_pin_n(power_down_pin_n),
    .supply_good_signal(supply_good_signal), .req(req), .rdata(rdata), .rvalid(rvalid),
    .refused(refused), .synth(synth), .clock_source_select(clock_source_select),
    .master_clock_divider_sel(master_clock_divider_sel),
    .core_clock_divider_sel(core_clock_divider_sel), .core_clock_gate(core_clock_gate),
    .internal_reset(internal_reset), .dac_mute(dac_mute),
    .clock_output_pin(clock_output_pin), .decim_sinc_sel_a(decim_sinc_sel_a),
    .decim_sinc_sel_b(decim_sinc_sel_b), .dac_input_sel_a(dac_input_sel_a),
    .dac_input_sel_b(dac_input_sel_b));
  ccpc_supply_model i_ccpc_supply_model (.clk(clk), .sag(sag),
    .supply_good_signal(supply_good_signal));

  ////////////////////////////////////////////////////////////////////////////////
  always #25 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // model: upper registers closed until core runs with lock
  function automatic int blk(input int a);
    return (a > 6) && !((m[0] & 1) && lck);
  endfunction

  // one control port request, taken at the second edge
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask

  task automatic wr(input int a, input int d);
    acc(1'b1, 1'b0, a[7:0], d[7:0]);
    `CHK("refused", blk(a) ? 1'b1 : 1'b0, refused)
    if (blk(a)) return;
    if (a == 0 && (m[0] & 1) != 0) d = (d & 8'hf9) | (m[0] & 8'h06);
    if (a == 0 && (d & 8'h81) == 8'h81 && !lck) d = d & 8'hfe;
    if (a < 6 || a == 9 || a == 10) m[a] = d;
  endtask

  task automatic rd(input int a);
    int e;
    e = blk(a) ? 0 : (a == 6) ? lck : (a < 6 || a == 9 || a == 10) ? m[a] : 0;
    acc(1'b0, 1'b1, a[7:0], 8'h00);
    `CHK("rdata", e[7:0], rdata)
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rd_refused", blk(a) ? 1'b1 : 1'b0, refused)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    for (n = 0; n < POR + 4 && internal_reset; n++) begin
      @(posedge clk);
      #1;
    end
    `CHK("por_len", 1'b1, n >= POR - 1 && n <= POR + 1)
    rd(9);
    for (int a = 1; a < 6; a++) begin
      rs = xs(rs);
      wr(a, rs[7:0]);
    end
    for (int a = 0; a < 7; a++) rd(a);
    foreach (md[i]) begin
      if (md[i][0]) begin
        wr(1, 8'h06);
        wr(2, 8'h59);
        wr(3, 8'h04);
        wr(4, 8'hf5);
      end
      wr(5, md[i]);
      `CHK("ratio", md[i][6:3], synth.integer_r)
      `CHK("numer", md[i][0] ? {m[3][7:0], m[4][7:0]} : 16'h0000, synth.numerator)
      `CHK("denom", md[i][0] ? {m[1][7:0], m[2][7:0]} : 16'h0000, synth.denominator)
      `CHK("frac", md[i][0], synth.fractional)
      `CHK("prediv", md[i][2:1], synth.prediv)
    end
    wr(0, 8'h06);
    `CHK("mdiv", 1'b1, master_clock_divider_sel)
    wr(0, 8'h87);
    `CHK("pll_en", 1'b1, synth.enable)
    @(posedge clk);
    #1;
    `CHK("gate", 1'b0, core_clock_gate)
    rd(6);
    repeat (LCK + 6) @(posedge clk);
    lck = 1;
    rd(6);
    wr(0, 8'h87);
    @(posedge clk);
    #1;
    `CHK("gate", 1'b1, core_clock_gate)
    wr(0, 8'h89);
    `CHK("src", 1'b1, clock_source_select)
    `CHK("cdiv", 1'b1, core_clock_divider_sel)
    wr(9, 8'h1f);
    `CHK("sel", 4'hf, {dac_input_sel_b, dac_input_sel_a, decim_sinc_sel_b, decim_sinc_sel_a})
    rd(9);
    rd(11);
    wr(6, 8'h00);
    rd(6);
    wr(10, 8'h18);
    n = 0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      #1;
      n += clock_output_pin;
    end
    `CHK("pdm_x2", 1'b1, n == 0)
    wr(10, 8'h11);
    n = 0;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      #1;
      n += clock_output_pin;
    end
    `CHK("clock_output_pin", 1'b1, n > 0)
    `CHK("mute", 1'b0, dac_mute)
    @(posedge clk);
    sag <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    `CHK("mute", 1'b1, dac_mute)
    @(posedge clk);
    power_down_pin_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    `CHK("pd", 2'h2, {internal_reset, core_clock_gate})
    // mid-run reset: only srst clears the mute, and the hold starts again
    @(posedge clk);
    power_down_pin_n <= 1'b1;
    srst             <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("rst_mute", 2'h2, {internal_reset, dac_mute})
    end_of_test();
  end
endmodule // test_ccpc_clock_control
